// [rsc_pkg.sv]
package rsc_pkg;

	// Strap-capable pins, one bit each.
	typedef struct packed {
		logic inband_mgmt_strap;
		logic ref_clk_out;
		logic irq_out_pin;
		logic flow_ctrl_strap;
		logic port6_mode_strap_hi;
		logic port6_mode_strap_lo;
		logic switch_start_strap;
		logic mgmt_sel_strap_hi;
		logic mgmt_sel_strap_lo;
	} rsc_strap_t;

	typedef enum logic [1:0] {
		MGMT_MDIO,
		MGMT_I2C,
		MGMT_SPI
	} rsc_mgmt_t;

	typedef enum logic [1:0] {
		P6_RGMII,
		P6_RMII,
		P6_RSVD,
		P6_MII
	} rsc_p6_t;

	// Internal weak pull direction of each strap pin, 1 = pull-up.
	localparam logic [8:0] STRAP_PULL_UP = 9'h0e7;
	localparam int STRAP_W = 9;
	localparam int SYNC_W  = 15;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_STRAP = 8'h04;
	localparam logic [7:0] OFS_GPIO  = 8'h08;
	localparam logic [7:0] OFS_LED   = 8'h0c;
	localparam logic [7:0] OFS_CFG   = 8'h10;

	// Control register fields.
	localparam int CTRL_SOFT_RST = 0;
	localparam int CTRL_IRQ_POL  = 1;
	localparam int CTRL_START    = 2;
	localparam int CTRL_RATE     = 3;
	localparam int CTRL_SRC_LSB  = 4;
	localparam int CTRL_SRC_W    = 3;
	localparam logic [6:0] CTRL_RST = 7'h00;

	// GPIO register fields.
	localparam int GPIO_OUT = 0;
	localparam int GPIO_DIR = 1;
	localparam int GPIO_IN  = 2;

	// LED register reset value: all LEDs dark (active low).
	localparam logic [2:0] LED_RST = 3'h7;

	// Timing.
	localparam int CLK_MHZ      = 200;
	localparam int SOFT_HOLD_NS = 100;
	localparam int SETTLE_NS    = 20;
	localparam int SOFT_HOLD_CYC = (SOFT_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;

endpackage

// [rsc_top.sv]
`timescale 1ns/100ps

// Functional notes
// - The active-low system reset holds the block and the core in reset while low.
// - While reset is low, every strap pin is left undriven.
// - Strap levels are sampled at reset release and kept as the configuration.
// - After reset release the management-select, flow-control and ref clock pins become driven outputs; the interrupt pin drives only while asserted.
// - Each strap pin has a weak internal pull that sets its default captured level.
// - A software reset repeats the float and capture sequence for every strap pin.
// - The interrupt pin polarity is programmable and is active low after reset.
// - The reference clock output runs at 25 or 125 MHz from the crystal or any PHY clock.
// - The general purpose pin is a register-controlled output or a readable input.
// - The management straps select MDIO for 00, I2C for 01 and SPI for 1x.
// - A switch-start strap of 0 holds forwarding until software sets the start bit.
// - The port 6 straps select RGMII, RMII, reserved or MII for 00, 01, 10 and 11.
// - The flow-control strap disables flow control at 0 and enables it at 1.
module rsc_top (
	// Clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// AHB-Lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	// Strap-capable pins
	input  wire rsc_pkg::rsc_strap_t strap_in,
	output rsc_pkg::rsc_strap_t     strap_out,
	output rsc_pkg::rsc_strap_t     strap_oe,
	output rsc_pkg::rsc_strap_t     strap_pull_up,
	// Clock sources
	input  wire logic               crystal_in,
	input  wire logic [3:0]         phy_rec_clk,
	output logic                    crystal_out,
	output logic                    ref_clk_125_sel,
	// General purpose pin
	input  wire logic               gpio_in,
	output logic                    gpio_out,
	output logic                    gpio_oe,
	// Core side
	input  wire logic               irq_req,
	output logic                    core_reset_n,
	output logic                    cfg_valid,
	output rsc_pkg::rsc_mgmt_t      mgmt_mode,
	output rsc_pkg::rsc_p6_t        port6_mode,
	output logic                    flow_ctrl_en,
	output logic                    forward_en,
	output logic                    inband_mgmt_en
);

	typedef enum logic [1:0] {
		ST_HOLD,
		ST_SETTLE,
		ST_RUN
	} rsc_state_t;

	rsc_state_t                     state;
	rsc_state_t                     next_state;
	logic [4:0]                     cnt;
	logic [4:0]                     next_cnt;
	logic [rsc_pkg::SYNC_W-1:0]     sync1;
	logic [rsc_pkg::SYNC_W-1:0]     sync2;
	rsc_pkg::rsc_strap_t            strap_cap;
	logic [6:0]                     ctrl;
	logic [2:0]                     led;
	logic [1:0]                     gpio_reg;
	logic                           soft_req;
	logic                           wr_pend;
	logic                           rd_pend;
	logic [7:0]                     wr_addr;
	logic [7:0]                     rd_addr;

	wire rsc_pkg::rsc_strap_t       strap_s = sync2[rsc_pkg::STRAP_W-1:0];
	wire logic                      gpio_s  = sync2[9];
	wire logic                      xtal_s  = sync2[10];
	wire logic [3:0]                phy_s   = sync2[14:11];
	wire logic                      addr_ok = hsel & htrans[1] & hready;
	wire logic                      run     = (state == ST_RUN);
	wire logic [2:0]                src     = ctrl[rsc_pkg::CTRL_SRC_LSB +: rsc_pkg::CTRL_SRC_W];
	wire logic                      irq_pol = ctrl[rsc_pkg::CTRL_IRQ_POL];
	wire logic                      cap_now = (state == ST_SETTLE) && (next_state == ST_RUN);

	// Reference clock source: 0 crystal, 1 to 4 the PHY recovered clocks.
	wire logic ref_src_lvl = (src == 3'h0) ? xtal_s :
		(src == 3'h1) ? phy_s[0] :
		(src == 3'h2) ? phy_s[1] :
		(src == 3'h3) ? phy_s[2] :
		(src == 3'h4) ? phy_s[3] : 1'b0;

	wire logic wr_ctrl = wr_pend & (wr_addr == rsc_pkg::OFS_CTRL);
	wire logic wr_gpio = wr_pend & (wr_addr == rsc_pkg::OFS_GPIO);
	wire logic wr_led  = wr_pend & (wr_addr == rsc_pkg::OFS_LED);

	wire logic [31:0] rd_ctrl  = {25'h0, ctrl[6:1], 1'b0};
	wire logic [31:0] rd_strap = {23'h0, strap_cap};
	wire logic [31:0] rd_gpio  = {29'h0, gpio_s, gpio_reg};
	wire logic [31:0] rd_led   = {29'h0, led};
	wire logic [31:0] rd_cfg   = {24'h0, cfg_valid, inband_mgmt_en, forward_en,
		flow_ctrl_en, port6_mode, mgmt_mode};
	wire logic [31:0] rd_mux = (rd_addr == rsc_pkg::OFS_CTRL)  ? rd_ctrl :
		(rd_addr == rsc_pkg::OFS_STRAP) ? rd_strap :
		(rd_addr == rsc_pkg::OFS_GPIO)  ? rd_gpio :
		(rd_addr == rsc_pkg::OFS_LED)   ? rd_led :
		(rd_addr == rsc_pkg::OFS_CFG)   ? rd_cfg : 32'h0;

	// Interrupt pin works open-drain: driven only while asserted, at the set polarity.
	wire logic irq_drive = run & irq_req;

	// Modes are decoded from the synchronised pins and taken at the capture edge, so that
	// they change together with the raw capture and never while the capture is valid.
	wire rsc_pkg::rsc_mgmt_t next_mgmt = strap_s.mgmt_sel_strap_hi ? rsc_pkg::MGMT_SPI :
		(strap_s.mgmt_sel_strap_lo ? rsc_pkg::MGMT_I2C : rsc_pkg::MGMT_MDIO);
	wire rsc_pkg::rsc_p6_t next_p6 = rsc_pkg::rsc_p6_t'({strap_s.port6_mode_strap_hi,
		strap_s.port6_mode_strap_lo});

	always_comb begin
		next_state = state;
		next_cnt = cnt + 5'h01;
		unique case (state)
			ST_HOLD: begin
				if (cnt == 5'(rsc_pkg::SOFT_HOLD_CYC - 1)) begin
					next_state = ST_SETTLE;
					next_cnt = 5'h00;
				end
			end
			ST_SETTLE: begin
				if (cnt == 5'(rsc_pkg::SETTLE_CYC - 1)) begin
					next_state = ST_RUN;
					next_cnt = 5'h00;
				end
			end
			ST_RUN: begin
				next_cnt = 5'h00;
			end
		endcase
		if (soft_req) begin
			next_state = ST_HOLD;
			next_cnt = 5'h00;
		end
	end

	// Pins pass two flip-flops before any logic looks at them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {phy_rec_clk, crystal_in, gpio_in, strap_in};
			sync2 <= sync1;
		end
	end

	// Settle covers the synchroniser depth before the pins are captured.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_SETTLE;
			cnt <= 5'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_cap <= rsc_pkg::STRAP_PULL_UP;
			cfg_valid <= 1'b0;
		end else if (cap_now) begin
			strap_cap <= strap_s;
			cfg_valid <= 1'b1;
		end else if (soft_req) begin
			cfg_valid <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mgmt_mode <= rsc_pkg::MGMT_SPI;
			port6_mode <= rsc_pkg::P6_RGMII;
			flow_ctrl_en <= 1'b0;
			forward_en <= 1'b0;
			inband_mgmt_en <= 1'b0;
			core_reset_n <= 1'b0;
		end else begin
			if (cap_now) begin
				mgmt_mode <= next_mgmt;
				port6_mode <= next_p6;
			end
			flow_ctrl_en <= run & strap_cap.flow_ctrl_strap;
			forward_en <= run & (strap_cap.switch_start_strap | ctrl[rsc_pkg::CTRL_START]);
			inband_mgmt_en <= run & strap_cap.inband_mgmt_strap;
			core_reset_n <= run;
		end
	end

	// Pads: undriven until run, then normal function; weak pulls always on.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_oe <= '0;
			strap_out <= '0;
			strap_pull_up <= rsc_pkg::STRAP_PULL_UP;
		end else begin
			strap_pull_up <= rsc_pkg::STRAP_PULL_UP;
			strap_out <= '{mgmt_sel_strap_lo: led[0], mgmt_sel_strap_hi: led[1],
				flow_ctrl_strap: led[2], irq_out_pin: irq_pol,
				ref_clk_out: ref_src_lvl, default: 1'b0};
			strap_oe <= '{mgmt_sel_strap_lo: run, mgmt_sel_strap_hi: run,
				flow_ctrl_strap: run, irq_out_pin: irq_drive,
				ref_clk_out: run, default: 1'b0};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gpio_out <= 1'b0;
			gpio_oe <= 1'b0;
			crystal_out <= 1'b0;
			ref_clk_125_sel <= 1'b0;
		end else begin
			gpio_out <= gpio_reg[rsc_pkg::GPIO_OUT];
			gpio_oe <= run & gpio_reg[rsc_pkg::GPIO_DIR];
			crystal_out <= ~xtal_s;
			ref_clk_125_sel <= ctrl[rsc_pkg::CTRL_RATE];
		end
	end

	// Registers written in the data phase of a write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= rsc_pkg::CTRL_RST;
			led <= rsc_pkg::LED_RST;
			gpio_reg <= 2'h0;
			soft_req <= 1'b0;
		end else begin
			soft_req <= wr_ctrl & hwdata[rsc_pkg::CTRL_SOFT_RST];
			if (wr_ctrl) begin
				ctrl <= {hwdata[6:1], 1'b0};
			end
			if (wr_led) begin
				led <= hwdata[2:0];
			end
			if (wr_gpio) begin
				gpio_reg <= hwdata[1:0];
			end
		end
	end

	// Writes take no wait state; reads take one so that hrdata comes from a flop.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= 8'h00;
			rd_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			wr_pend <= addr_ok & hwrite;
			rd_pend <= addr_ok & ~hwrite;
			hresp <= 1'b0;
			if (addr_ok) begin
				wr_addr <= haddr[7:0];
				rd_addr <= haddr[7:0];
			end
			if (addr_ok & ~hwrite) begin
				hreadyout <= 1'b0;
			end else if (rd_pend) begin
				hreadyout <= 1'b1;
				hrdata <= rd_mux;
			end
		end
	end

endmodule

// [rsc_monitor.sv]
`timescale 1ns/100ps

module rsc_monitor (
	// Clock and reset
	input wire logic                hclk,
	input wire logic                hresetn,
	// Bus
	input wire logic                hsel,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic                hready,
	input wire logic                hreadyout,
	input wire logic                hresp,
	// Pins and core side
	input wire rsc_pkg::rsc_strap_t strap_oe,
	input wire rsc_pkg::rsc_strap_t strap_pull_up,
	input wire logic                core_reset_n,
	input wire logic                cfg_valid,
	input wire rsc_pkg::rsc_mgmt_t  mgmt_mode,
	input wire rsc_pkg::rsc_p6_t    port6_mode,
	input wire logic                flow_ctrl_en,
	input wire logic                forward_en
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_oe_off_hold: assert property (!core_reset_n |-> strap_oe == 9'h000)
		else $error("strap pin driven while core held");
	a_oe_run_drive: assert property (core_reset_n |-> strap_oe.flow_ctrl_strap
		&& strap_oe.mgmt_sel_strap_lo && !strap_oe.port6_mode_strap_lo)
		else $error("strap pin drive wrong in run");
	a_pull_fixed: assert property (strap_pull_up == rsc_pkg::STRAP_PULL_UP)
		else $error("pull direction changed");
	a_cfg_stable: assert property (cfg_valid && $past(cfg_valid) |->
		$stable(mgmt_mode) && $stable(port6_mode))
		else $error("captured mode moved");
	a_core_gate: assert property (!core_reset_n |-> !forward_en && !flow_ctrl_en)
		else $error("forwarding while core held");
	a_valid_first: assert property ($rose(core_reset_n) |-> cfg_valid)
		else $error("core released before capture");
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=>
		!hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
endmodule

bind rsc_top rsc_monitor mon_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .strap_oe(strap_oe),
	.strap_pull_up(strap_pull_up), .core_reset_n(core_reset_n), .cfg_valid(cfg_valid),
	.mgmt_mode(mgmt_mode), .port6_mode(port6_mode), .flow_ctrl_en(flow_ctrl_en),
	.forward_en(forward_en)
);

// [rsc_board.sv]
`timescale 1ns/100ps

// Board side of the strap pins: an undriven pin settles to the fitted
// resistor, or to the weak internal pull when none is fitted.
module rsc_board (
	input wire logic [8:0]  strap_out,
	input wire logic [8:0]  strap_oe,
	input wire logic [8:0]  strap_pull_up,
	input wire logic [8:0]  ext_fit,
	input wire logic [8:0]  ext_val,
	output logic [8:0]      strap_in
);
	assign strap_in = (strap_oe & strap_out) | (~strap_oe &
		((ext_fit & ext_val) | (~ext_fit & strap_pull_up)));
endmodule

// [reset_strap_capture_tb.sv]
`timescale 1ns/100ps

module reset_strap_capture_tb;
	logic                hclk, hresetn, hsel, hwrite, hreadyout, gpio_in, gpio_out, gpio_oe;
	logic                irq_req, crystal_in, crystal_out, cfg_valid, forward_en, ref_clk_125_sel;
	logic [31:0]         haddr, hwdata, hrdata;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic [3:0]          phy_rec_clk;
	logic [8:0]          ext_fit, ext_val, strap_in_w;
	rsc_pkg::rsc_strap_t strap_out, strap_oe, strap_pull_up;
	int                  error_cnt, checked, i;
	logic [8:0]          cases [4] = '{9'h000, 9'h159, 9'h00e, 9'h033};

	rsc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .strap_in(strap_in_w),
		.strap_out(strap_out), .strap_oe(strap_oe), .strap_pull_up(strap_pull_up),
		.crystal_in(crystal_in), .phy_rec_clk(phy_rec_clk), .crystal_out(crystal_out),
		.ref_clk_125_sel(ref_clk_125_sel), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .irq_req(irq_req), .core_reset_n(), .cfg_valid(cfg_valid),
		.mgmt_mode(), .port6_mode(), .flow_ctrl_en(), .forward_en(forward_en),
		.inband_mgmt_en());
	rsc_board board_u (.strap_out(strap_out), .strap_oe(strap_oe),
		.strap_pull_up(strap_pull_up), .ext_fit(ext_fit), .ext_val(ext_val),
		.strap_in(strap_in_w));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task test_done;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Waits for an edge at which the given flag is high; a stuck flag ends the run.
	task wait_hi(input int sel);
		int n;
		n = 0;
		@(posedge hclk);
		while ((sel ? cfg_valid : hreadyout) !== 1'b1) begin
			n++;
			if (n > 100) begin
				error_cnt++;
				test_done;
			end
			@(posedge hclk);
		end
	endtask

	task bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		wait_hi(0);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_hi(0);
		rd = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(a, 1'b0, 32'h0, x);
		chk(x, e);
	endtask

	function automatic logic [31:0] exp_cfg(input logic [8:0] s, input logic st);
		return {24'h0, 1'b1, s[8], s[2] | st, s[5], s[4], s[3], s[1], ~s[1] & s[0]};
	endfunction

	initial begin
		#200000;
		error_cnt++;
		test_done;
	end

	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, irq_req, crystal_in} = '0;
		{hsize, gpio_in, phy_rec_clk, ext_fit, ext_val} = {3'h2, 1'b1, 22'h0};
		repeat (16) @(posedge hclk);
		chk({23'h0, strap_oe}, 32'h0);
		hresetn <= 1'b1;
		wait_hi(1);
		rdc(rsc_pkg::OFS_STRAP, {23'h0, rsc_pkg::STRAP_PULL_UP});
		rdc(rsc_pkg::OFS_CFG, exp_cfg(rsc_pkg::STRAP_PULL_UP, 1'b0));
		ext_fit <= 9'h1ff;
		for (i = 0; i < 4; i++) begin
			ext_val <= cases[i];
			wr(rsc_pkg::OFS_CTRL, 32'h1);
			repeat (3) @(posedge hclk);
			wait_hi(1);
			rdc(rsc_pkg::OFS_STRAP, {23'h0, cases[i]});
			rdc(rsc_pkg::OFS_CFG, exp_cfg(cases[i], 1'b0));
			ext_val <= ~cases[i];
			repeat (4) @(posedge hclk);
			rdc(rsc_pkg::OFS_CFG, exp_cfg(cases[i], 1'b0));
		end
		chk({31'h0, forward_en}, 32'h0);
		irq_req <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({30'h0, strap_oe.irq_out_pin, strap_out.irq_out_pin}, 32'h2);
		wr(rsc_pkg::OFS_CTRL, 32'h0e);
		repeat (3) @(posedge hclk);
		chk({29'h0, strap_out.irq_out_pin, forward_en, ref_clk_125_sel}, 32'h7);
		rdc(rsc_pkg::OFS_CFG, exp_cfg(cases[3], 1'b1));
		crystal_in <= 1'b1;
		repeat (4) @(posedge hclk);
		chk({30'h0, crystal_out, strap_out.ref_clk_out}, 32'h1);
		wr(rsc_pkg::OFS_CTRL, 32'h20);
		crystal_in <= 1'b0;
		phy_rec_clk <= 4'h2;
		repeat (4) @(posedge hclk);
		chk({31'h0, strap_out.ref_clk_out}, 32'h1);
		phy_rec_clk <= 4'h0;
		repeat (4) @(posedge hclk);
		chk({31'h0, strap_out.ref_clk_out}, 32'h0);
		irq_req <= 1'b0;
		wr(rsc_pkg::OFS_GPIO, 32'h3);
		repeat (2) @(posedge hclk);
		chk({30'h0, gpio_oe, gpio_out}, 32'h3);
		rdc(rsc_pkg::OFS_GPIO, 32'h7);
		gpio_in <= 1'b0;
		repeat (3) @(posedge hclk);
		rdc(rsc_pkg::OFS_GPIO, 32'h3);
		wr(rsc_pkg::OFS_LED, 32'h5);
		repeat (2) @(posedge hclk);
		chk({29'h0, strap_out.flow_ctrl_strap, strap_out.mgmt_sel_strap_hi,
			strap_out.mgmt_sel_strap_lo}, 32'h5);
		wr(8'h40, 32'hffffffff);
		rdc(8'h40, 32'h0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({22'h0, cfg_valid, strap_oe}, 32'h0);
		hresetn <= 1'b1;
		wait_hi(1);
		rdc(rsc_pkg::OFS_STRAP, {23'h0, ~cases[3]});
		rdc(rsc_pkg::OFS_CFG, exp_cfg(~cases[3], 1'b0));
		test_done;
	end
endmodule
